/* inc/aux_limit_regs.vh */
// Register map, field positions and reset values of the auxiliary monitor limit block.
// Function
// RULE1: Alarm byte 0x70 bit 1 is high exactly while input b is above its high alarm limit.
// RULE2: Alarm byte 0x70 bit 0 is high exactly while input b is below its low alarm limit.
// RULE3: Warning byte 0x74 bit 1 is high exactly while input b is above its high warning limit.
// RULE4: Warning byte 0x74 bit 0 is high exactly while input b is below its low warning limit.
// RULE5: Alarm byte 0x71 bit 7 is high exactly while input c is above its high alarm limit.
// RULE6: Alarm byte 0x71 bit 6 is high exactly while input c is below its low alarm limit.
// RULE7: Every threshold is a 16-bit shadowed register whose default is all zeros.
// RULE8: The input b measurement is held as an unsigned 16-bit volatile value at 0x66 and 0x67.
// RULE9: The input c measurement is held as an unsigned 16-bit volatile value at 0x68 and 0x69.
// RULE10: Each 16-bit value takes two byte addresses, high byte first; compares are unsigned.
`ifndef AUX_LIMIT_REGS_VH
`define AUX_LIMIT_REGS_VH

// ----------------------------------------------------------------------------
// Byte addresses
// ----------------------------------------------------------------------------
`define ADDR_B_HI_ALARM     8'h18
`define ADDR_B_LO_ALARM     8'h1a
`define ADDR_B_HI_WARN      8'h1c
`define ADDR_B_LO_WARN      8'h1e
`define ADDR_C_HI_ALARM     8'h20
`define ADDR_C_LO_ALARM     8'h22
`define ADDR_MEAS_B         8'h66
`define ADDR_MEAS_C         8'h68
`define ADDR_ALARM_FLAGS0   8'h70
`define ADDR_ALARM_FLAGS1   8'h71
`define ADDR_WARN_FLAGS0    8'h74
`define ADDR_IRQ_STATUS     8'h80
`define ADDR_IRQ_MASK       8'h81

// ----------------------------------------------------------------------------
// Flag bit positions and reset values
// ----------------------------------------------------------------------------
`define BIT_B_HI_ALARM      1
`define BIT_B_LO_ALARM      0
`define BIT_B_HI_WARN       1
`define BIT_B_LO_WARN       0
`define BIT_C_HI_ALARM      7
`define BIT_C_LO_ALARM      6
`define THRESH_RESET        16'h0000
`define MEAS_RESET          16'h0000
`define IRQ_MASK_RESET      8'h00

// Interrupt status layout: one sticky bit per flag rising edge.
`define IRQ_B_HI_ALARM      0
`define IRQ_B_LO_ALARM      1
`define IRQ_B_HI_WARN       2
`define IRQ_B_LO_WARN       3
`define IRQ_C_HI_ALARM      4
`define IRQ_C_LO_ALARM      5

`endif

/* verilog/limit_compare.v */
// Unsigned compare of one measurement against a high and a low limit.
`timescale 1ns/1ps
`default_nettype none
module limit_compare (
    input  wire [15:0] measure,
    input  wire [15:0] high_limit,
    input  wire [15:0] low_limit,
    output wire        above_high,
    output wire        below_low
);
    // Strict unsigned compares; equality raises neither flag.
    assign above_high = (measure > high_limit);   // see RULE10
    assign below_low  = (measure < low_limit);    // see RULE10
endmodule
`default_nettype wire

/* verilog/aux_monitor_limit_compare.v */
// Threshold registers, measurement holding, alarm flags for inputs b and c, and warning flags for input b.
`timescale 1ns/1ps
`default_nettype none
`include "aux_limit_regs.vh"
module aux_monitor_limit_compare (
    input  wire        clock,
    input  wire        srst,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    input  wire [15:0] meas_b_in,
    input  wire        meas_b_valid,
    input  wire [15:0] meas_c_in,
    input  wire        meas_c_valid,
    output wire [7:0]  alarm_flags0,
    output wire [7:0]  alarm_flags1,
    output wire [7:0]  warn_flags0,
    output wire        irq
);

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    // Threshold index: 0 b high alarm, 1 b low alarm, 2 b high warn,
    // 3 b low warn, 4 c high alarm, 5 c low alarm.
    reg  [15:0] thresh_q [0:5];
    reg  [15:0] meas_b_q;
    reg  [15:0] meas_c_q;
    reg  [5:0]  flag_q;
    reg  [5:0]  irq_status_q;
    reg  [5:0]  irq_mask_q;
    wire [5:0]  flag_d;
    wire        b_hi_alarm;
    wire        b_lo_alarm;
    wire        b_hi_warn;
    wire        b_lo_warn;
    wire        c_hi_alarm;
    wire        c_lo_alarm;
    integer     i;

    // Maps either byte address of a threshold (bit 0 masked off) to its index, 7 if none.
    function [2:0] thresh_index;
        input [7:0] addr;
        begin
            case (addr & 8'hfe)
                `ADDR_B_HI_ALARM: thresh_index = 3'h0;
                `ADDR_B_LO_ALARM: thresh_index = 3'h1;
                `ADDR_B_HI_WARN:  thresh_index = 3'h2;
                `ADDR_B_LO_WARN:  thresh_index = 3'h3;
                `ADDR_C_HI_ALARM: thresh_index = 3'h4;
                `ADDR_C_LO_ALARM: thresh_index = 3'h5;
                default:          thresh_index = 3'h7;
            endcase
        end
    endfunction

    // Picks the byte of a 16-bit value that an address selects, high byte at even.
    function [7:0] byte_of;
        input [15:0] value;
        input [7:0]  addr;
        begin
            byte_of = addr[0] ? value[7:0] : value[15:8];   // see RULE10
        end
    endfunction

    // ------------------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------------------
    limit_compare u_b_alarm (
        .measure    (meas_b_q),
        .high_limit (thresh_q[0]),
        .low_limit  (thresh_q[1]),
        .above_high (b_hi_alarm),
        .below_low  (b_lo_alarm)
    );

    limit_compare u_b_warn (
        .measure    (meas_b_q),
        .high_limit (thresh_q[2]),
        .low_limit  (thresh_q[3]),
        .above_high (b_hi_warn),
        .below_low  (b_lo_warn)
    );

    limit_compare u_c_alarm (
        .measure    (meas_c_q),
        .high_limit (thresh_q[4]),
        .low_limit  (thresh_q[5]),
        .above_high (c_hi_alarm),
        .below_low  (c_lo_alarm)
    );

    // Flag order follows the interrupt status layout.
    assign flag_d = {c_lo_alarm, c_hi_alarm, b_lo_warn, b_hi_warn, b_lo_alarm, b_hi_alarm};

    // ------------------------------------------------------------------------
    // Flag outputs
    // ------------------------------------------------------------------------
    // Live flags, set and cleared by the compare alone.
    assign alarm_flags0 = {6'h00, flag_q[`IRQ_B_HI_ALARM], flag_q[`IRQ_B_LO_ALARM]};  // see RULE1
    assign warn_flags0  = {6'h00, flag_q[`IRQ_B_HI_WARN], flag_q[`IRQ_B_LO_WARN]};    // see RULE3
    assign alarm_flags1 = {flag_q[`IRQ_C_HI_ALARM], flag_q[`IRQ_C_LO_ALARM], 6'h00};  // see RULE5
    assign irq          = |(irq_status_q & irq_mask_q);

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    // Measurements, thresholds, flags and interrupt state.
    always @(posedge clock) begin
        if (srst) begin
            for (i = 0; i < 6; i = i + 1) begin
                thresh_q[i] <= `THRESH_RESET;                     // see RULE7
            end
            meas_b_q     <= `MEAS_RESET;
            meas_c_q     <= `MEAS_RESET;
            flag_q       <= 6'h00;
            irq_status_q <= 6'h00;
            irq_mask_q   <= 6'h00;
        end else begin
            if (meas_b_valid) begin
                meas_b_q <= meas_b_in;                            // see RULE8
            end
            if (meas_c_valid) begin
                meas_c_q <= meas_c_in;                            // see RULE9
            end
            // Flags track the compare each cycle, both setting and clearing.
            flag_q <= flag_d; // see RULE1 RULE2 RULE3 RULE4 RULE5 RULE6
            if (reg_wr && thresh_index(reg_addr) != 3'h7) begin
                if (reg_addr[0]) begin
                    thresh_q[thresh_index(reg_addr)][7:0] <= reg_wdata;   // see RULE10
                end else begin
                    thresh_q[thresh_index(reg_addr)][15:8] <= reg_wdata;  // see RULE10
                end
            end
            if (reg_wr && reg_addr == `ADDR_IRQ_MASK) begin
                irq_mask_q <= reg_wdata[5:0];
            end
            // A new rising flag wins over a write-one clear in the same cycle.
            if (reg_wr && reg_addr == `ADDR_IRQ_STATUS) begin
                irq_status_q <= (irq_status_q & ~reg_wdata[5:0]) | (flag_d & ~flag_q);
            end else begin
                irq_status_q <= irq_status_q | (flag_d & ~flag_q);
            end
        end
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    // Read data stands in the cycle after the read strobe; unmapped reads zero.
    always @(posedge clock) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (thresh_index(reg_addr) != 3'h7) begin
                reg_rdata <= byte_of(thresh_q[thresh_index(reg_addr)], reg_addr);
            end else begin
                case (reg_addr)
                    `ADDR_MEAS_B,
                    `ADDR_MEAS_B + 8'h01: reg_rdata <= byte_of(meas_b_q, reg_addr); // see RULE8
                    `ADDR_MEAS_C,
                    `ADDR_MEAS_C + 8'h01: reg_rdata <= byte_of(meas_c_q, reg_addr); // see RULE9
                    `ADDR_ALARM_FLAGS0:   reg_rdata <= alarm_flags0;
                    `ADDR_ALARM_FLAGS1:   reg_rdata <= alarm_flags1;
                    `ADDR_WARN_FLAGS0:    reg_rdata <= warn_flags0;
                    `ADDR_IRQ_STATUS:     reg_rdata <= {2'h0, irq_status_q};
                    `ADDR_IRQ_MASK:       reg_rdata <= {2'h0, irq_mask_q};
                    default:              reg_rdata <= 8'h00;
                endcase
            end
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule
`default_nettype wire

/* testbench/aux_limit_checker.sv */
// Assertion checker for the auxiliary monitor limit block.
`timescale 1ns/1ps
`default_nettype none
module aux_limit_checker (
    input wire logic       clock,
    input wire logic       srst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [15:0] meas_b_in,
    input wire logic       meas_b_valid,
    input wire logic [15:0] meas_c_in,
    input wire logic       meas_c_valid,
    input wire logic [7:0] alarm_flags0,
    input wire logic [7:0] alarm_flags1,
    input wire logic [7:0] warn_flags0,
    input wire logic       irq
);
    logic [15:0] thr [6];
    logic [15:0] mb_q, mc_q;
    logic [5:0]  mk_q;
    logic [7:0]  exp_byte;
    wire  [7:0]  off    = reg_addr - 8'h18;
    wire         in_thr = reg_addr >= 8'h18 && reg_addr <= 8'h23;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // Shadow the thresholds and captured measurements.
    always @(posedge clock) begin
        if (srst) begin
            thr  <= '{default: 16'h0000};
            mb_q <= 16'h0000;
            mc_q <= 16'h0000;
            mk_q <= 6'h00;
        end else begin
            if (reg_wr && in_thr && off[0]) thr[off[3:1]][7:0] <= reg_wdata;
            if (reg_wr && in_thr && !off[0]) thr[off[3:1]][15:8] <= reg_wdata;
            if (meas_b_valid) mb_q <= meas_b_in;
            if (meas_c_valid) mc_q <= meas_c_in;
            if (reg_wr && reg_addr == 8'h81) mk_q <= reg_wdata[5:0];
        end
    end
    // Byte a read of the current address must return.
    always_comb begin
        case (reg_addr)
            8'h66: exp_byte = mb_q[15:8];
            8'h67: exp_byte = mb_q[7:0];
            8'h68: exp_byte = mc_q[15:8];
            8'h69: exp_byte = mc_q[7:0];
            default: exp_byte = off[0] ? thr[off[3:1]][7:0] : thr[off[3:1]][15:8];
        endcase
    end
    sequence data_read;
        reg_rd && (in_thr || reg_addr inside {[8'h66:8'h69]});
    endsequence
    a_b_hi_alarm: assert property (1'b1 |=> alarm_flags0[1] == $past(mb_q > thr[0]))
        else $error("b high alarm flag wrong");
    a_b_lo_alarm: assert property ((mb_q < thr[1]) |=> alarm_flags0[0])
        else $error("b low alarm flag missing");
    a_b_lo_clear: assert property (!(mb_q < thr[1]) |=> !alarm_flags0[0])
        else $error("b low alarm flag stuck");
    a_b_hi_warn: assert property (1'b1 |=> warn_flags0[1] == $past(mb_q > thr[2]))
        else $error("b high warning flag wrong");
    a_b_lo_warn: assert property (1'b1 |=> warn_flags0[0] == $past(mb_q < thr[3]))
        else $error("b low warning flag wrong");
    a_c_hi_alarm: assert property (1'b1 |=> alarm_flags1[7] == $past(mc_q > thr[4]))
        else $error("c high alarm flag wrong");
    a_c_lo_alarm: assert property (1'b1 |=> alarm_flags1[6] == $past(mc_q < thr[5]))
        else $error("c low alarm flag wrong");
    a_spare_bits_zero: assert property (
        {alarm_flags0[7:2], alarm_flags1[5:0], warn_flags0[7:2]} == 18'h0)
        else $error("unused flag bit set");
    a_irq_on_rise: assert property ($rose(alarm_flags0[1]) && mk_q[0] |-> irq)
        else $error("irq missing on b high alarm rise");
    a_data_readback: assert property (data_read |=> reg_rdata == $past(exp_byte))
        else $error("read byte wrong");
endmodule
bind aux_monitor_limit_compare aux_limit_checker chk (.clock(clock), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .meas_b_in(meas_b_in), .meas_b_valid(meas_b_valid),
    .meas_c_in(meas_c_in), .meas_c_valid(meas_c_valid), .alarm_flags0(alarm_flags0),
    .alarm_flags1(alarm_flags1), .warn_flags0(warn_flags0), .irq(irq));
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the auxiliary monitor limit block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clock, srst, reg_wr, reg_rd, meas_b_valid, meas_c_valid, rd_d, irq;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, alarm_flags0, alarm_flags1, warn_flags0;
    logic [15:0] meas_b_in, meas_c_in, mb, mc;
    logic [15:0] th [6];
    logic [31:0] seed;
    logic [7:0]  exp_q [$];
    int          failures, tests_run, t, i;
    aux_monitor_limit_compare dut (.clock(clock), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .meas_b_in(meas_b_in), .meas_b_valid(meas_b_valid), .meas_c_in(meas_c_in),
        .meas_c_valid(meas_c_valid), .alarm_flags0(alarm_flags0),
        .alarm_flags1(alarm_flags1), .warn_flags0(warn_flags0), .irq(irq));
    // Free-running 40 MHz clock.
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    function automatic [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input [7:0] seen, input [7:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input [7:0] a, input [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input [7:0] a, input [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock);
        reg_rd   <= 1'b0;
    endtask
    task automatic wth(input [2:0] k, input [15:0] v);
        wr(8'h18 + {4'h0, k, 1'b0}, v[15:8]);
        wr(8'h19 + {4'h0, k, 1'b0}, v[7:0]);
        th[k] = v;
    endtask
    task automatic meas;
        @(posedge clock);
        meas_b_in    <= mb;
        meas_c_in    <= mc;
        meas_b_valid <= 1'b1;
        meas_c_valid <= 1'b1;
        @(posedge clock);
        meas_b_valid <= 1'b0;
        meas_c_valid <= 1'b0;
    endtask
    task automatic flags;
        rd(8'h70, {6'h00, mb > th[0], mb < th[1]});
        rd(8'h71, {mc > th[4], mc < th[5], 6'h00});
        rd(8'h74, {6'h00, mb > th[2], mb < th[3]});
    endtask
    task automatic irq_is(input logic e);
        @(negedge clock);
        check({7'h00, irq}, {7'h00, e}, "irq");
    endtask
    // Read data is compared one cycle after each read strobe.
    always @(posedge clock) begin
        rd_d <= reg_rd;
        if (rd_d && exp_q.size() > 0)
            check(reg_rdata, exp_q.pop_front(), "read byte");
    end
    // Main sequence.
    initial begin
        {srst, reg_wr, reg_rd, meas_b_valid, meas_c_valid} = 5'b10000;
        {reg_addr, reg_wdata, meas_b_in, meas_c_in, mb, mc} = '0;
        th = '{default: 16'h0000};
        {failures, tests_run, seed} = {32'd0, 32'd0, 32'h9a6de2f1};
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        for (i = 0; i < 12; i++) rd(8'h18 + i[7:0], 8'h00);
        for (i = 0; i < 4; i++) rd(8'h66 + i[7:0], 8'h00);
        rd(8'h30, 8'h00);
        flags;
        $display("test reset_values done");
        for (t = 0; t < 24; t++) begin
            for (i = 0; i < 6; i++) begin
                seed = lfsr(seed);
                wth(i[2:0], seed[15:0]);
            end
            seed = lfsr(seed);
            mb = (t % 3 == 0) ? th[t % 4] : seed[15:0];
            mc = (t % 3 == 1) ? th[4 + t % 2] : seed[31:16];
            meas;
            wr(8'h70, 8'hff);
            flags;
            i = t % 12;
            rd(8'h18 + i[7:0], i[0] ? th[i / 2][7:0] : th[i / 2][15:8]);
            rd(8'h66, mb[15:8]);
            rd(8'h69, mc[7:0]);
        end
        $display("test random_limits done");
        for (i = 0; i < 6; i++) wth(i[2:0], 16'h8000);
        {mb, mc} = {16'h8000, 16'h8000};
        meas;
        wr(8'h80, 8'h3f);
        wr(8'h81, 8'h01);
        rd(8'h80, 8'h00);
        mb = 16'h9000;
        meas;
        rd(8'h80, 8'h05);
        rd(8'h81, 8'h01);
        irq_is(1'b1);
        wr(8'h81, 8'h00);
        irq_is(1'b0);
        wr(8'h81, 8'h04);
        irq_is(1'b1);
        wr(8'h80, 8'h05);
        irq_is(1'b0);
        mc = 16'h1000;
        meas;
        rd(8'h80, 8'h20);
        wr(8'h81, 8'h20);
        irq_is(1'b1);
        $display("test interrupt done");
        for (i = 0; i < 10 && exp_q.size() > 0; i++) @(posedge clock);
        if (exp_q.size() > 0) failures++;
        end_sim;
    end
endmodule
`default_nettype wire
